/* File: hdl/pin_function_pkg.sv */
// constants for the pin function controller: register map, field layout, pin masks
package pin_function_pkg;

  // printed register offsets, kept as register indices; byte address is index times four
  localparam logic [31:0] PORT_A_DIRECTION_LOW_OFS           = 32'hFFFFD106;
  localparam logic [31:0] PORT_A_FUNCTION_CTRL_4_OFS         = 32'hFFFFD110;
  localparam logic [31:0] PORT_A_FUNCTION_CTRL_3_OFS         = 32'hFFFFD112;
  localparam logic [31:0] PORT_A_FUNCTION_CTRL_2_OFS         = 32'hFFFFD114;
  localparam logic [31:0] PORT_A_FUNCTION_CTRL_1_OFS         = 32'hFFFFD116;
  localparam logic [31:0] PORT_B_DIRECTION_HIGH_OFS          = 32'hFFFFD184;
  localparam logic [31:0] PORT_B_DIRECTION_LOW_OFS           = 32'hFFFFD186;
  localparam logic [31:0] PORT_B_FUNCTION_CTRL_HIGH_OFS      = 32'hFFFFD18E;
  localparam logic [31:0] PORT_B_FUNCTION_CTRL_2_OFS         = 32'hFFFFD194;
  localparam logic [31:0] PORT_B_FUNCTION_CTRL_1_OFS         = 32'hFFFFD196;
  localparam logic [31:0] PORT_E_DIRECTION_LOW_OFS           = 32'hFFFFD306;
  localparam logic [31:0] PORT_E_FUNCTION_CTRL_4_OFS         = 32'hFFFFD310;
  localparam logic [31:0] PORT_E_FUNCTION_CTRL_3_OFS         = 32'hFFFFD312;
  localparam logic [31:0] PORT_E_FUNCTION_CTRL_2_OFS         = 32'hFFFFD314;
  localparam logic [31:0] PORT_E_FUNCTION_CTRL_1_OFS         = 32'hFFFFD316;
  localparam logic [31:0] INTERRUPT_OUTPUT_FUNCTION_CTRL_OFS = 32'hFFFFD322;

  localparam int NUM_REGS = 16;
  localparam logic [31:0] REG_OFFSET [NUM_REGS] = '{
    PORT_A_DIRECTION_LOW_OFS, PORT_A_FUNCTION_CTRL_4_OFS, PORT_A_FUNCTION_CTRL_3_OFS,
    PORT_A_FUNCTION_CTRL_2_OFS, PORT_A_FUNCTION_CTRL_1_OFS, PORT_B_DIRECTION_HIGH_OFS,
    PORT_B_DIRECTION_LOW_OFS, PORT_B_FUNCTION_CTRL_HIGH_OFS, PORT_B_FUNCTION_CTRL_2_OFS,
    PORT_B_FUNCTION_CTRL_1_OFS, PORT_E_DIRECTION_LOW_OFS, PORT_E_FUNCTION_CTRL_4_OFS,
    PORT_E_FUNCTION_CTRL_3_OFS, PORT_E_FUNCTION_CTRL_2_OFS, PORT_E_FUNCTION_CTRL_1_OFS,
    INTERRUPT_OUTPUT_FUNCTION_CTRL_OFS};

  // storage index of each register
  localparam logic [3:0] IDX_PA_DIR   = 4'h0;
  localparam logic [3:0] IDX_PA_FC4   = 4'h1;
  localparam logic [3:0] IDX_PA_FC3   = 4'h2;
  localparam logic [3:0] IDX_PA_FC2   = 4'h3;
  localparam logic [3:0] IDX_PA_FC1   = 4'h4;
  localparam logic [3:0] IDX_PB_DIR_H = 4'h5;
  localparam logic [3:0] IDX_PB_DIR_L = 4'h6;
  localparam logic [3:0] IDX_PB_FC_H  = 4'h7;
  localparam logic [3:0] IDX_PB_FC2   = 4'h8;
  localparam logic [3:0] IDX_PB_FC1   = 4'h9;
  localparam logic [3:0] IDX_PE_DIR   = 4'hA;
  localparam logic [3:0] IDX_PE_FC4   = 4'hB;
  localparam logic [3:0] IDX_PE_FC3   = 4'hC;
  localparam logic [3:0] IDX_PE_FC2   = 4'hD;
  localparam logic [3:0] IDX_PE_FC1   = 4'hE;
  localparam logic [3:0] IDX_INTERRUPT_OUTPUT_FUNCTION_CTRL     = 4'hF;

  // registers that are function-control (reserved bit per nibble)
  localparam logic [15:0] CTRL_REG_SET    = 16'h7B9E;
  // registers at 32-bit aligned addresses that allow a 32-bit access
  localparam logic [15:0] WIDE_ACCESS_SET = 16'h292A;

  localparam logic [15:0] REG_RESET       = 16'h0000;
  localparam logic [15:0] FULL_WRITE_MASK = 16'hFFFF;
  localparam logic [15:0] CTRL_WRITE_MASK = 16'h7777;

  // function field: three bits per pin in each nibble, top bit of nibble reserved
  localparam int         FIELD_WIDTH = 3;
  localparam int         FIELD_PITCH = 4;
  localparam logic [2:0] FUNC_PORT   = 3'h0;

  // port A pins not bonded out on the small package, and pins taken by boundary scan
  localparam logic [15:0] PA_UNBONDED = 16'hFC24;
  localparam logic [15:0] PA_SCAN_PINS = 16'h0398;
  localparam logic [15:0] ALL_PINS     = 16'hFFFF;
  localparam logic [15:0] NO_PINS      = 16'h0000;

endpackage : pin_function_pkg

/* File: hdl/pin_route.sv */
// per-port routing of direction and function fields to registered pin controls
`timescale 1ns/1ps
module pin_route (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // register contents
  input  wire logic [15:0] direction,
  input  wire logic [63:0] function_ctrl,
  // pin masks
  input  wire logic [15:0] usable,
  input  wire logic [15:0] scan_owned,
  // pin controls
  output logic      [15:0] pin_oe,
  output logic      [47:0] pin_function
);

  logic [15:0] next_pin_oe;
  logic [47:0] next_pin_function;

  function automatic logic is_port(input logic [2:0] field);
    is_port = (field == pin_function_pkg::FUNC_PORT);
  endfunction : is_port

  for (genvar i = 0; i < 16; i++) begin : g_pin
    logic [2:0] field;
    assign field = function_ctrl[i*pin_function_pkg::FIELD_PITCH +: pin_function_pkg::FIELD_WIDTH];
    // direction counts only for a bonded pin in port mode, not under scan override
    assign next_pin_oe[i] = direction[i] & is_port(field)
                            & usable[i] & ~scan_owned[i];
    assign next_pin_function[i*3 +: 3] = scan_owned[i] ? pin_function_pkg::FUNC_PORT : field;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe       <= 16'h0000;
      pin_function <= 48'h0000_0000_0000;
    end else begin
      pin_oe       <= next_pin_oe;
      pin_function <= next_pin_function;
    end
  end

endmodule : pin_route

/* File: hdl/pin_function_controller.sv */
// pin function controller: APB register file and pin direction / function routing
//
// Summary of operation
// - port A direction bit one makes its pin output, zero makes it input
// - direction bit acts only while the pin is in port mode
// - port A direction bits 15 to 10, 5 and 2 have no effect
// - port A direction register is 16 bits, read/write, resets to zero
// - every direction, function and interrupt-output register resets to zero, read/write
// - aligned registers take 8/16/32-bit access; others only 8 and 16 bits
// - debug select low forces scan pins and break acknowledge over software choice
// - after reset every multiplexed pin is a port pin
// - function field is three bits, code 000 means port; software writes documented codes
// - reserved function-control bits read zero; software writes zero
`timescale 1ns/1ps
module pin_function_controller (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // debug mode select pin, active low
  input  wire logic        debug_mode_select_n,
  // port A pin controls
  output logic      [15:0] port_a_oe,
  output logic      [47:0] port_a_function,
  output logic      [15:0] port_a_scan_owned,
  output logic             debug_break_acknowledge,
  // port B pin controls
  output logic      [15:0] port_b_oe,
  output logic      [47:0] port_b_function,
  output logic             port_b16_oe,
  output logic      [2:0]  port_b16_function,
  // port E pin controls
  output logic      [15:0] port_e_oe,
  output logic      [47:0] port_e_function,
  // interrupt output function control contents
  output logic      [15:0] interrupt_output_ctrl
);

  logic [15:0] regs [pin_function_pkg::NUM_REGS];
  logic [15:0] next_regs [pin_function_pkg::NUM_REGS];
  logic [31:0] next_prdata;
  logic        next_b16_oe;
  logic [2:0]  next_b16_function;
  logic [15:0] next_scan_owned;
  logic        next_break_ack;
  logic [15:0] next_irq_ctrl;

  logic        hit;
  logic [3:0]  idx;
  logic        setup;
  logic        access;
  logic        bad_size;
  logic        wr_ok;
  logic [15:0] lane_mask;
  logic [15:0] scan_now;

  // address decode: printed offset is the index, so compare address bits above the word
  function automatic logic [4:0] decode(input logic [31:0] addr);
    decode = 5'h00;
    for (int r = 0; r < pin_function_pkg::NUM_REGS; r++) begin
      if (addr[31:2] == pin_function_pkg::REG_OFFSET[r][29:0]) begin
        decode = {1'b1, r[3:0]};
      end
    end
  endfunction : decode

  // bits that software can change in a register
  function automatic logic [15:0] write_mask(input logic [3:0] r);
    if (pin_function_pkg::CTRL_REG_SET[r]) begin
      write_mask = pin_function_pkg::CTRL_WRITE_MASK;
    end else begin
      write_mask = pin_function_pkg::FULL_WRITE_MASK;
    end
  endfunction : write_mask

  assign {hit, idx} = decode(paddr);
  assign setup      = psel & ~penable;
  assign access     = psel & penable;
  // upper lanes only on a write to a register that allows 32-bit access
  assign bad_size   = pwrite & (|pstrb[3:2]) & ~pin_function_pkg::WIDE_ACCESS_SET[idx];
  assign wr_ok      = access & pwrite & hit & ~bad_size;
  assign lane_mask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // zero-wait slave; error on unmapped address or disallowed size
  assign pready  = 1'b1;
  assign pslverr = access & (~hit | bad_size);

  // register file next state
  always_comb begin
    for (int r = 0; r < pin_function_pkg::NUM_REGS; r++) begin
      next_regs[r] = regs[r];
    end
    if (wr_ok) begin
      next_regs[idx] = (regs[idx] & ~lane_mask)
                       | (pwdata[15:0] & lane_mask & write_mask(idx));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < pin_function_pkg::NUM_REGS; r++) begin
        regs[r] <= pin_function_pkg::REG_RESET;
      end
    end else begin
      for (int r = 0; r < pin_function_pkg::NUM_REGS; r++) begin
        regs[r] <= next_regs[r];
      end
    end
  end

  // read data captured in the setup cycle, valid through the access cycle
  always_comb begin
    next_prdata = prdata;
    if (setup) begin
      next_prdata = hit ? {16'h0000, regs[idx] & write_mask(idx)} : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // debug override: scan pins and break acknowledge taken from software
  assign scan_now = debug_mode_select_n ? pin_function_pkg::NO_PINS
                                        : pin_function_pkg::PA_SCAN_PINS;

  // port B pin 16, interrupt-output control and debug status
  always_comb begin
    next_b16_function = regs[pin_function_pkg::IDX_PB_FC_H][2:0];
    next_b16_oe       = regs[pin_function_pkg::IDX_PB_DIR_H][0]
                        & (next_b16_function == pin_function_pkg::FUNC_PORT);
    next_scan_owned   = scan_now;
    next_break_ack    = ~debug_mode_select_n;
    next_irq_ctrl     = regs[pin_function_pkg::IDX_INTERRUPT_OUTPUT_FUNCTION_CTRL];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b16_oe             <= 1'b0;
      port_b16_function       <= 3'h0;
      port_a_scan_owned       <= 16'h0000;
      debug_break_acknowledge <= 1'b0;
      interrupt_output_ctrl   <= 16'h0000;
    end else begin
      port_b16_oe             <= next_b16_oe;
      port_b16_function       <= next_b16_function;
      port_a_scan_owned       <= next_scan_owned;
      debug_break_acknowledge <= next_break_ack;
      interrupt_output_ctrl   <= next_irq_ctrl;
    end
  end

  pin_route u_port_a (
    .pclk          (pclk),
    .presetn       (presetn),
    .direction     (regs[pin_function_pkg::IDX_PA_DIR]),
    .function_ctrl ({regs[pin_function_pkg::IDX_PA_FC4], regs[pin_function_pkg::IDX_PA_FC3],
                     regs[pin_function_pkg::IDX_PA_FC2], regs[pin_function_pkg::IDX_PA_FC1]}),
    .usable        (~pin_function_pkg::PA_UNBONDED),
    .scan_owned    (scan_now),
    .pin_oe        (port_a_oe),
    .pin_function  (port_a_function)
  );

  pin_route u_port_b (
    .pclk          (pclk),
    .presetn       (presetn),
    .direction     (regs[pin_function_pkg::IDX_PB_DIR_L]),
    .function_ctrl ({32'h0000_0000, regs[pin_function_pkg::IDX_PB_FC2],
                     regs[pin_function_pkg::IDX_PB_FC1]}),
    .usable        (pin_function_pkg::ALL_PINS),
    .scan_owned    (pin_function_pkg::NO_PINS),
    .pin_oe        (port_b_oe),
    .pin_function  (port_b_function)
  );

  pin_route u_port_e (
    .pclk          (pclk),
    .presetn       (presetn),
    .direction     (regs[pin_function_pkg::IDX_PE_DIR]),
    .function_ctrl ({regs[pin_function_pkg::IDX_PE_FC4], regs[pin_function_pkg::IDX_PE_FC3],
                     regs[pin_function_pkg::IDX_PE_FC2], regs[pin_function_pkg::IDX_PE_FC1]}),
    .usable        (pin_function_pkg::ALL_PINS),
    .scan_owned    (pin_function_pkg::NO_PINS),
    .pin_oe        (port_e_oe),
    .pin_function  (port_e_function)
  );

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_dir_sets_output: assert property (
    (regs[pin_function_pkg::IDX_PA_DIR][0] && regs[pin_function_pkg::IDX_PA_FC1][2:0] == 3'h0)
      |=> port_a_oe[0])
    else $error("port A pin 0 not output with direction set in port mode");

  a_other_func_input: assert property (
    (regs[pin_function_pkg::IDX_PA_FC1][6:4] != 3'h0) |=> !port_a_oe[1])
    else $error("port A pin 1 driven while another function selected");

  a_unbonded_inert: assert property (
    (port_a_oe & pin_function_pkg::PA_UNBONDED) == 16'h0000)
    else $error("unbonded port A pin enabled as output");

  a_dir_write_lands: assert property (
    (wr_ok && idx == pin_function_pkg::IDX_PA_DIR && pstrb[1:0] == 2'b11)
      |=> regs[pin_function_pkg::IDX_PA_DIR] == $past(pwdata[15:0]))
    else $error("port A direction write not stored");

  a_wide_refused: assert property (
    (access && pwrite && hit && pstrb[3] && idx == pin_function_pkg::IDX_PA_FC3)
      |-> pslverr ##1 $stable(regs[pin_function_pkg::IDX_PA_FC3]))
    else $error("32-bit write to narrow register accepted");

  a_scan_override: assert property (
    !debug_mode_select_n |=> (port_a_scan_owned == pin_function_pkg::PA_SCAN_PINS)
      && ((port_a_oe & pin_function_pkg::PA_SCAN_PINS) == 16'h0000) && debug_break_acknowledge)
    else $error("debug mode did not take the scan pins");

  a_field_passes: assert property (
    debug_mode_select_n |=> port_e_function[2:0] == $past(regs[pin_function_pkg::IDX_PE_FC1][2:0]))
    else $error("port E pin 0 function does not follow its field");

  a_reserved_zero: assert property (
    (regs[pin_function_pkg::IDX_PE_FC4] & ~pin_function_pkg::CTRL_WRITE_MASK) == 16'h0000)
    else $error("reserved function-control bit set");

  a_byte_lane_keep: assert property (
    (wr_ok && idx == pin_function_pkg::IDX_PB_DIR_L && pstrb[1:0] == 2'b01)
      |=> regs[pin_function_pkg::IDX_PB_DIR_L][15:8]
          == $past(regs[pin_function_pkg::IDX_PB_DIR_L][15:8]))
    else $error("byte write changed the other lane");

  a_unmapped_err: assert property (
    (access && !hit) |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  a_dir_clear_input: assert property (
    !regs[pin_function_pkg::IDX_PA_DIR][0] |=> !port_a_oe[0])
    else $error("port A pin 0 driven with direction clear");

  a_b16_other_func: assert property (
    (regs[pin_function_pkg::IDX_PB_FC_H][2:0] != 3'h0) |=> !port_b16_oe)
    else $error("port B pin 16 driven while another function selected");

  a_dir_holds: assert property (
    !wr_ok |=> $stable(regs[pin_function_pkg::IDX_PA_DIR]))
    else $error("port A direction changed without a write");

  a_read_upper_zero: assert property (
    (access && !pwrite) |-> prdata[31:16] == 16'h0000)
    else $error("read data above the register width not zero");

  a_irq_copy: assert property (
    1'b1 |=> interrupt_output_ctrl == $past(regs[pin_function_pkg::IDX_INTERRUPT_OUTPUT_FUNCTION_CTRL]))
    else $error("interrupt output control does not follow its register");

  a_read_no_error: assert property (
    (access && !pwrite && hit) |-> !pslverr)
    else $error("read of a mapped register refused");

  a_narrow_write_ok: assert property (
    (access && pwrite && hit && pstrb[3:2] == 2'b00) |-> !pslverr)
    else $error("8 or 16-bit write to a mapped register refused");

  a_wide_accepted: assert property (
    (access && pwrite && hit && idx == pin_function_pkg::IDX_PA_FC4) |-> !pslverr)
    else $error("write to a 32-bit capable register refused");

  a_scan_func_port: assert property (
    !debug_mode_select_n
      |=> (port_a_function[11:9] == 3'h0) && (port_a_function[14:12] == 3'h0))
    else $error("scan pin kept a software function in debug mode");

  a_pin15_port_func: assert property (
    (regs[pin_function_pkg::IDX_PA_FC4][14:12] == 3'h0) |=> port_a_function[47:45] == 3'h0)
    else $error("port A pin 15 not a port pin with code 000");

  a_reserved_read_zero: assert property (
    (access && !pwrite && hit && pin_function_pkg::CTRL_REG_SET[idx])
      |-> (prdata[15:0] & ~pin_function_pkg::CTRL_WRITE_MASK) == 16'h0000)
    else $error("reserved function-control bit read as one");

  c_wide_write: cover property (wr_ok && pstrb == 4'hF);
  c_port_output: cover property (port_a_oe[0] ##1 !port_a_oe[0]);
  c_debug_entry: cover property ($fell(debug_mode_select_n));
  c_slave_error: cover property (pslverr);
  c_debug_write: cover property (!debug_mode_select_n && wr_ok);

endmodule : pin_function_controller

/* File: test/port_pin_function_controller_bench.sv */
// self-checking bench for the pin function controller
`timescale 1ns/1ps
module port_pin_function_controller_bench;
  typedef struct packed {
    logic        rd;
    logic        err;
    logic [31:0] data;
  } note_t;

  logic        pclk                = 1'b0;
  logic        presetn             = 1'b0;
  logic        psel                = 1'b0;
  logic        penable             = 1'b0;
  logic        pwrite              = 1'b0;
  logic [31:0] paddr               = 32'h0;
  logic [31:0] pwdata              = 32'h0;
  logic [3:0]  pstrb               = 4'h0;
  logic        debug_mode_select_n = 1'b1;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] port_a_oe;
  logic [47:0] port_a_function;
  logic [15:0] port_a_scan_owned;
  logic        debug_break_acknowledge;
  logic [15:0] port_b_oe;
  logic [47:0] port_b_function;
  logic        port_b16_oe;
  logic [2:0]  port_b16_function;
  logic [15:0] port_e_oe;
  logic [47:0] port_e_function;
  logic [15:0] interrupt_output_ctrl;
  logic [15:0] shadow [16];
  logic [31:0] seed                = 32'h0A97FF29;
  note_t       note_q [$];
  int          err_total           = 0;
  int          num_checks          = 0;

  always #2 pclk = ~pclk;

  pin_function_controller dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .debug_mode_select_n, .port_a_oe, .port_a_function,
    .port_a_scan_owned, .debug_break_acknowledge, .port_b_oe, .port_b_function, .port_b16_oe,
    .port_b16_function, .port_e_oe, .port_e_function, .interrupt_output_ctrl);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [31:0] addr(input int i);
    return {pin_function_pkg::REG_OFFSET[i][29:0], 2'b00};
  endfunction : addr

  function automatic logic [63:0] fcs(input int b);
    return {shadow[b], shadow[b+1], shadow[b+2], shadow[b+3]};
  endfunction : fcs

  task automatic report_and_stop();
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic err, input logic [31:0] exp);
    note_q.push_back('{~wr, err, exp});
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_rd(input int i);
    apb(1'b0, addr(i), 32'h0, 4'h0, 1'b0, {16'h0, shadow[i]});
  endtask : reg_rd

  task automatic reg_wr(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [15:0] m;
    logic        bad;
    if (pin_function_pkg::CTRL_REG_SET[i]) d = d & 32'hFFFF7777;
    bad = (s[3] | s[2]) & ~pin_function_pkg::WIDE_ACCESS_SET[i];
    m = pin_function_pkg::CTRL_REG_SET[i] ? pin_function_pkg::CTRL_WRITE_MASK
                                          : pin_function_pkg::FULL_WRITE_MASK;
    m = m & {{8{s[1]}}, {8{s[0]}}};
    if (!bad) shadow[i] = (shadow[i] & ~m) | (d[15:0] & m);
    apb(1'b1, addr(i), d, s, bad, 32'h0);
  endtask : reg_wr

  task automatic pins_chk(input logic dbg);
    logic [63:0] fa, fe, fb;
    logic [15:0] sc, oa, oe;
    logic [47:0] na, ne;
    logic [7:0]  ob;
    logic [23:0] nb;
    repeat (4) @(posedge pclk);
    #1;
    fa = fcs(pin_function_pkg::IDX_PA_FC4);
    fe = fcs(pin_function_pkg::IDX_PE_FC4);
    fb = {32'h0, shadow[pin_function_pkg::IDX_PB_FC2], shadow[pin_function_pkg::IDX_PB_FC1]};
    sc = dbg ? pin_function_pkg::PA_SCAN_PINS : pin_function_pkg::NO_PINS;
    for (int p = 0; p < 16; p++) begin
      oa[p] = shadow[0][p] & (fa[4*p+:3] == 3'h0) & ~pin_function_pkg::PA_UNBONDED[p] & ~sc[p];
      na[3*p+:3] = sc[p] ? 3'h0 : fa[4*p+:3];
      oe[p] = shadow[10][p] & (fe[4*p+:3] == 3'h0);
      ne[3*p+:3] = fe[4*p+:3];
      ob[p%8] = shadow[6][p%8] & (fb[4*(p%8)+:3] == 3'h0);
      nb[3*(p%8)+:3] = fb[4*(p%8)+:3];
    end
    chk(64'(port_a_oe), 64'(oa));
    chk(64'(port_a_function), 64'(na));
    chk(64'(port_a_scan_owned), 64'(sc));
    chk(64'(debug_break_acknowledge), 64'(dbg));
    chk(64'(port_e_oe), 64'(oe));
    chk(64'(port_e_function), 64'(ne));
    chk(64'(port_b_oe), 64'({shadow[6][15:8], ob}));
    chk(64'(port_b_function), 64'(nb));
    chk(64'(port_b16_oe), 64'(shadow[5][0] & (shadow[7][2:0] == 3'h0)));
    chk(64'(port_b16_function), 64'(shadow[7][2:0]));
    chk(64'(interrupt_output_ctrl), 64'(shadow[15]));
  endtask : pins_chk

  always @(posedge pclk) begin
    note_t n;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (note_q.size() == 0) begin
        chk(64'h1, 64'h0);
      end else begin
        n = note_q.pop_front();
        chk(64'(pslverr), 64'(n.err));
        if (n.rd) chk(64'(prdata), 64'(n.data));
      end
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    report_and_stop();
  end

  initial begin
    foreach (shadow[i]) shadow[i] = 16'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++) reg_rd(i);
    pins_chk(1'b0);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      reg_wr(i, pin_function_pkg::CTRL_REG_SET[i] ? seed & 32'hFFFF9999 : seed, 4'h3);
      reg_rd(i);
    end
    pins_chk(1'b0);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      reg_wr(i, seed, 4'h1);
      reg_wr(i, ~seed, 4'h2);
      reg_rd(i);
      seed = lfsr(seed);
      reg_wr(i, seed & 32'hFFFF9999, 4'hF);
      reg_rd(i);
    end
    pins_chk(1'b0);
    apb(1'b1, 32'h0, seed, 4'h3, 1'b1, 32'h0);
    apb(1'b0, addr(0) + 32'h4, 32'h0, 4'h0, 1'b1, 32'h0);
    reg_wr(0, 32'h0000FFFF, 4'h3);
    for (int i = 1; i < 5; i++) reg_wr(i, 32'h0, 4'h3);
    pins_chk(1'b0);
    @(posedge pclk) debug_mode_select_n <= 1'b0;
    pins_chk(1'b1);
    reg_wr(3, 32'h00001111, 4'h3);
    pins_chk(1'b1);
    @(posedge pclk) debug_mode_select_n <= 1'b1;
    pins_chk(1'b0);
    @(posedge pclk) presetn <= 1'b0;
    foreach (shadow[i]) shadow[i] = 16'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 16; i++) reg_rd(i);
    pins_chk(1'b0);
    report_and_stop();
  end
endmodule : port_pin_function_controller_bench
